//--- verilog/lsrr_top.sv
// Low-supply detector and runaway counter combined into one internal reset source.
`timescale 1ns/10ps
module lsrr_top
  import lsrr_pkg::*;
#(
  parameter int unsigned COUNT_W = RUNAWAY_BITS
) (
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Oscillation clock tick and supply comparator
  input  wire logic        osc_tick,
  input  wire logic        supply_low_async,
  // CPU status
  input  wire lsrr_mode_t  cpu_mode,
  input  wire logic        ram_write_busy,
  input  wire lsrr_clear_t clear_wr,
  input  wire logic        flag_clear,
  // Outputs
  output logic             internal_reset,
  output logic             low_supply_flag,
  output logic             stop_release,
  output logic             runaway_clear_readback
);

  // ----------------------------------------------------------------
  // Supply comparator synchroniser
  // ----------------------------------------------------------------
  logic sync1_reg;
  logic sync2_reg;
  logic supply_low;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else if (clk_en) begin
      sync1_reg <= supply_low_async;
      sync2_reg <= sync1_reg;
    end
  end
  assign supply_low = sync2_reg;

  // ----------------------------------------------------------------
  // Low-supply flag
  // ----------------------------------------------------------------
  // Only reset or flag_clear clears the flag, not an internal reset, so software can see why the
  // chip restarted after an internal reset.
  always_ff @(posedge clk) begin
    if (reset) begin
      low_supply_flag <= FLAG_RESET_VAL;
    end else if (clk_en) begin
      if (supply_low) begin
        low_supply_flag <= 1'b1;
      end else if (flag_clear) begin
        low_supply_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Runaway counter
  // ----------------------------------------------------------------
  logic [COUNT_W-1:0] count_reg;
  logic               count_clear;
  logic               timeout;
  logic               sw_clear;

  assign sw_clear = clear_wr.wr_en && (clear_wr.wr_data == CLEAR_BIT_VALUE);
  assign count_clear = sw_clear || internal_reset || cpu_mode.osc_stopped
                     || cpu_mode.sleep_entry || cpu_mode.timebase_entry
                     || cpu_mode.watch_entry;
  assign timeout = osc_tick && !cpu_mode.cpu_stopped && (&count_reg);

  always_ff @(posedge clk) begin
    if (reset) begin
      count_reg <= '0;
    end else if (clk_en) begin
      if (count_clear) begin
        count_reg <= '0;
      end else if (osc_tick && !cpu_mode.cpu_stopped) begin
        count_reg <= count_reg + COUNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      runaway_clear_readback <= 1'b1;
    end else if (clk_en && clear_wr.wr_en) begin
      runaway_clear_readback <= clear_wr.wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  lsrr_state_t state_reg;
  lsrr_state_t state_next;
  logic [PULSE_CNT_W-1:0] pulse_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LSRR_IDLE: begin
        if (timeout) begin
          state_next = LSRR_PULSE;
        end else if (supply_low) begin
          state_next = ram_write_busy ? LSRR_WAIT_WR : LSRR_PULSE;
        end
      end
      LSRR_WAIT_WR: begin
        if (!ram_write_busy) begin
          state_next = LSRR_PULSE;
        end
      end
      LSRR_PULSE: begin
        // New requests are dropped while the pulse stands.
        if (pulse_reg == PULSE_LAST) begin
          state_next = LSRR_IDLE;
        end
      end
      default: state_next = LSRR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= LSRR_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_reg <= '0;
    end else if (clk_en) begin
      pulse_reg <= (state_next == LSRR_PULSE && state_reg == LSRR_PULSE)
                 ? pulse_reg + PULSE_CNT_W'(1) : '0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      internal_reset <= 1'b0;
      stop_release   <= 1'b0;
    end else if (clk_en) begin
      internal_reset <= (state_next == LSRR_PULSE);
      stop_release   <= (state_next == LSRR_PULSE) && cpu_mode.stop_mode
                        && (state_reg != LSRR_PULSE);
    end
  end

endmodule // lsrr_top

//--- verilog/lsrr_pkg.sv
// Package holding constants and carriers for the low-supply and runaway reset block.
package lsrr_pkg;

  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned RUNAWAY_BITS    = 20;
  localparam int unsigned RESET_MACHINE_CYCLES = 5;
  localparam int unsigned PULSE_CNT_W     = 3;
  localparam logic [PULSE_CNT_W-1:0] PULSE_LAST = 3'(RESET_MACHINE_CYCLES - 1);

  // ----------------------------------------------------------------
  // Reset and clear values
  // ----------------------------------------------------------------
  localparam logic FLAG_RESET_VAL  = 1'b0;
  localparam logic CLEAR_BIT_VALUE = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LSRR_IDLE    = 2'b00,
    LSRR_WAIT_WR = 2'b01,
    LSRR_PULSE   = 2'b11
  } lsrr_state_t;

  typedef struct packed {
    logic stop_mode;
    logic sleep_entry;
    logic timebase_entry;
    logic watch_entry;
    logic cpu_stopped;
    logic osc_stopped;
  } lsrr_mode_t;

  typedef struct packed {
    logic wr_en;
    logic wr_data;
  } lsrr_clear_t;

endpackage

//--- sim/lsrr_properties.sv
// Port checker for the low-supply and runaway reset block.
`timescale 1ns/10ps
module lsrr_properties
  import lsrr_pkg::*;
(
  // Inputs
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        osc_tick,
  input wire logic        supply_low_async,
  input wire logic        ram_write_busy,
  input wire logic        flag_clear,
  input wire lsrr_clear_t clear_wr,
  // Outputs
  input wire logic        internal_reset,
  input wire logic        low_supply_flag,
  input wire logic        stop_release,
  input wire logic        runaway_clear_readback
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_flag_set_sync: assert property ($rose(low_supply_flag) |-> $past(supply_low_async, 3))
    else $error("flag rose without a synced low supply");
  a_flag_sticky: assert property (low_supply_flag && !flag_clear |=> low_supply_flag)
    else $error("flag dropped");
  a_pulse_five: assert property ($rose(internal_reset) |-> internal_reset[*5] ##1 !internal_reset)
    else $error("reset pulse length");
  a_ram_write_wait: assert property (ram_write_busy |=> !$rose(internal_reset))
    else $error("reset during RAM write");
  a_stop_exit: assert property (stop_release |-> $rose(internal_reset) ##1 !stop_release)
    else $error("stop release not at reset start");
  a_reset_cause: assert property ($rose(internal_reset) |-> $past(osc_tick) || low_supply_flag)
    else $error("reset without cause");
  a_clear_write: assert property (clear_wr.wr_en |=> runaway_clear_readback == $past(clear_wr.wr_data))
    else $error("clear bit not written");
  a_clear_kept: assert property (!clear_wr.wr_en |=> $stable(runaway_clear_readback))
    else $error("clear bit changed");
  c_low: cover property ($rose(internal_reset) && low_supply_flag);
  c_stop: cover property (stop_release);
  c_timeout: cover property ($rose(internal_reset) && $past(osc_tick));
endmodule // lsrr_properties

//--- sim/lsrr_top_test.sv
// Self-checking bench for the low-supply and runaway reset block.
`timescale 1ns/10ps
module lsrr_top_test
  import lsrr_pkg::*;
;
  // A short counter keeps the timeout run brief.
  localparam int CW = 4;
  logic        clk, reset, clk_en, osc_tick, supply_low_async, ram_write_busy, flag_clear;
  int          hit = 0;
  logic        internal_reset, low_supply_flag, stop_release, runaway_clear_readback;
  lsrr_mode_t  cpu_mode;
  lsrr_clear_t clear_wr;
  int          bad_count, checks_done, n;
  lsrr_top #(.COUNT_W(CW)) dut_u (.clk, .reset, .clk_en, .osc_tick, .supply_low_async,
    .cpu_mode, .ram_write_busy, .clear_wr, .flag_clear, .internal_reset, .low_supply_flag,
    .stop_release, .runaway_clear_readback);
  always #25 clk = ~clk;
  always @(posedge clk) if (internal_reset === 1'b1) hit <= hit + 1;
  task automatic w(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic s(input int k);
    w(k);
    @(negedge clk);
  endtask
  task automatic chk(input string what, input logic [5:0] e, input logic [5:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %0d seen %0d", what, e, g);
    end
  endtask
  task automatic clr(input logic v);
    w(1);
    clear_wr <= '{1'b1, v};
    w(1);
    clear_wr <= '{1'b0, 1'b0};
  endtask
  task automatic t_low(input logic busy);
    w(1);
    supply_low_async <= 1'b1;
    ram_write_busy <= busy;
    cpu_mode.stop_mode <= !busy;
    w(3);
    supply_low_async <= 1'b0;
    cpu_mode.stop_mode <= 1'b0;
    s(busy ? 4 : 0);
    chk("rst", !busy, internal_reset);
    chk("stop_exit", !busy, stop_release);
    w(1);
    ram_write_busy <= 1'b0;
    s(3);
    chk("rst_held", 1, internal_reset);
    s(4);
    chk("rst_done", 0, internal_reset);
    chk("flag", 1, low_supply_flag);
  endtask
  task automatic t_runaway();
    int base;
    chk("clr_kept", 1, runaway_clear_readback);
    clr(1'b0);
    osc_tick <= 1'b1;
    for (n = 0; internal_reset !== 1'b1 && n < 40; n++) s(1);
    chk("timeout", 2 ** CW, n);
    s(6);
    base = hit;
    // Each pass is shorter than one interval, so only the clears keep reset away.
    for (int i = 0; i < 5; i++) begin
      w(6);
      cpu_mode <= lsrr_mode_t'(i == 4 ? 6'h00 : (i == 3 ? 6'h01 : 6'h10 >> i));
      clr(i == 4 ? 1'b0 : 1'b1);
      cpu_mode <= lsrr_mode_t'(6'h00);
    end
    chk("no_timeout_clr", 0, 6'(hit - base));
    w(1);
    cpu_mode <= lsrr_mode_t'(6'h02);
    s(24);
    chk("no_timeout_halt", 0, 6'(hit - base));
    chk("clr_val", 0, runaway_clear_readback);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    {clk, reset, clk_en, osc_tick, supply_low_async, ram_write_busy, flag_clear} = 7'h30;
    {cpu_mode, clear_wr, bad_count, checks_done} = '0;
    s(4);
    chk("clr_reset", 1, runaway_clear_readback);
    w(1);
    reset <= 1'b0;
    t_low(1'b0);
    w(1);
    flag_clear <= 1'b1;
    w(1);
    flag_clear <= 1'b0;
    t_low(1'b1);
    t_runaway();
    tally_and_finish();
  end
  initial begin
    w(3000);
    bad_count++;
    tally_and_finish();
  end
endmodule // lsrr_top_test
bind lsrr_top lsrr_properties chk_u (.clk, .reset, .osc_tick, .supply_low_async,
  .ram_write_busy, .flag_clear, .clear_wr, .internal_reset, .low_supply_flag, .stop_release,
  .runaway_clear_readback);
